// >>> common/kpsc_pkg.sv
package kpsc_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [15:0] KPSC_IDX_STATUS = 16'h00D4;
    localparam logic [15:0] KPSC_IDX_SIZE = 16'h00D5;
    localparam logic [15:0] KPSC_IDX_ORD_LO = 16'h00D6;
    localparam logic [15:0] KPSC_IDX_ORD_HI = 16'h00D7;
    localparam logic [15:0] KPSC_IDX_MANUAL = 16'h00D8;
    localparam logic [15:0] KPSC_IDX_IRQ = 16'hFF94;

    // apb geometry
    localparam int KPSC_AW = 20;
    localparam int KPSC_DW = 32;
    localparam logic [1:0] KPSC_WORD_PAD = 2'h0;
    localparam logic [1:0] KPSC_IDX_PAD = 2'h0;

    // keypad_matrix_size fields
    localparam int KPSC_ROW_LSB = 3;
    localparam int KPSC_COL_LSB = 0;
    localparam int KPSC_CNT_W = 3;
    localparam logic [7:0] KPSC_SIZE_WMASK = 8'h3F;

    // column order fields
    localparam int KPSC_SLOT_W = 3;
    localparam int KPSC_NUM_SLOTS = 5;
    localparam int KPSC_ORDER_W = 15;
    localparam logic [7:0] KPSC_ORD_HI_WMASK = 8'h7F;

    // matrix limits
    localparam int KPSC_MAX_ROWS = 6;
    localparam int KPSC_MAX_COLS = 5;
    localparam logic [2:0] KPSC_MAX_ROWS_C = 3'h6;
    localparam logic [2:0] KPSC_MAX_COLS_C = 3'h5;

    // status register bits
    localparam int KPSC_ST_KEY_DETECT_FLAG = 1;
    localparam int KPSC_ST_AUTO = 2;
    localparam logic [4:0] KPSC_MANUAL_WMASK = 5'h1F;

    // ext_irq_control bits
    localparam int KPSC_IRQ_KP_FLAG = 0;
    localparam int KPSC_IRQ_KP_EN = 1;
    localparam int KPSC_IRQ_SB_FLAG = 2;
    localparam int KPSC_IRQ_SB_EN = 3;
    localparam int KPSC_IRQ_CA_FLAG = 4;
    localparam int KPSC_IRQ_CA_EN = 5;
    localparam int KPSC_IRQ_PD_SEL = 7;
    localparam logic [7:0] KPSC_IRQ_WMASK = 8'hAA;

    // reset values
    localparam logic [7:0] KPSC_RST_BYTE = 8'h00;

    // configuration handed to the scan sequencer
    typedef struct packed {
        logic auto_scan_enable;
        logic [KPSC_CNT_W-1:0] column_count;
        logic [KPSC_ORDER_W-1:0] column_order;
        logic [KPSC_MAX_COLS-1:0] manual_columns;
    } kpsc_scan_cfg_t;

    // column index to one-hot column drive; out-of-range drives nothing
    function automatic logic [KPSC_MAX_COLS-1:0] kpsc_onehot(input logic [KPSC_SLOT_W-1:0] idx);
        logic [KPSC_MAX_COLS-1:0] res;
        res = '0;
        for (int i = 0; i < KPSC_MAX_COLS; i++) begin
            if (idx == KPSC_SLOT_W'(i)) begin
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction : kpsc_onehot

endpackage : kpsc_pkg

// >>> verilog/kpsc_scan.sv
`timescale 1ns/10ps
`default_nettype none

module kpsc_scan
    import kpsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and pacing
    input var kpsc_scan_cfg_t cfg,
    input wire logic tick,
    // column drive
    output logic [KPSC_SLOT_W-1:0] slot_ff,
    output logic [KPSC_MAX_COLS-1:0] col_drive_ff
);

    logic [KPSC_SLOT_W-1:0] slot_col [KPSC_NUM_SLOTS];
    logic [KPSC_SLOT_W-1:0] eff_count;
    logic [KPSC_SLOT_W-1:0] last_slot;
    logic [KPSC_SLOT_W-1:0] nxt_slot;
    logic [KPSC_MAX_COLS-1:0] nxt_col_drive;
    logic slot_out_of_range;

    // split the packed order into its five slots
    for (genvar g = 0; g < KPSC_NUM_SLOTS; g++) begin : g_slot
        assign slot_col[g] = cfg.column_order[g*KPSC_SLOT_W +: KPSC_SLOT_W];
    end

    // count above the pin limit is clamped so the walk never leaves the slot table
    assign eff_count = (cfg.column_count > KPSC_MAX_COLS_C) ? KPSC_MAX_COLS_C
                                                            : cfg.column_count;
    assign last_slot = eff_count - 3'h1;
    assign slot_out_of_range = (slot_ff >= eff_count);

    // advance first to fifth slot, wrapping at the column count
    assign nxt_slot = (!cfg.auto_scan_enable || slot_out_of_range) ? 3'h0 :
                      (!tick) ? slot_ff :
                      (slot_ff == last_slot) ? 3'h0 : slot_ff + 3'h1;

    // automatic mode drives the slot's column; bypass passes the firmware pattern
    assign nxt_col_drive = !cfg.auto_scan_enable ? cfg.manual_columns :
                           (eff_count == 3'h0) ? '0 :
                           kpsc_onehot(slot_col[nxt_slot]);

    // sequencer state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_ff <= '0;
            col_drive_ff <= '0;
        end else begin
            slot_ff <= nxt_slot;
            col_drive_ff <= nxt_col_drive;
        end
    end

endmodule : kpsc_scan

`default_nettype wire

// >>> verilog/kpsc_top.sv
// Function
// - row count field, bits 5:3, max 6
// - column count field, bits 2:0, max 5
// - size counts only matter in automatic scanning
// - fifteen-bit order, five three-bit column slots
// - automatic scan walks slots up to count
// - order split low and high byte registers
// - slot value is binary column index
// - size and order registers reset zero
// - keypad flag bit 0, clears on read
// - bit 1 enables keypad interrupt
// - clock alarm flag bit 4, read clears
// - bit 5 enables clock alarm interrupt
// - bit 7 powerdown select, bit 6 unused
// - scan enable picks automatic or bypass
// - key found sets detect flag, read clears
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

module kpsc_top
    import kpsc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [KPSC_AW-1:0] PADDR,
    input wire logic [KPSC_DW-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic PREADY,
    output logic [KPSC_DW-1:0] PRDATA,
    output logic PSLVERR,
    // events from neighbouring blocks
    input wire logic SCAN_TICK,
    input wire logic KEY_FOUND,
    input wire logic RTC_EVENT,
    input wire logic USB_EVENT,
    // keypad matrix
    output logic [KPSC_MAX_COLS-1:0] COL_DRIVE,
    output logic [KPSC_SLOT_W-1:0] SCAN_SLOT,
    output logic [KPSC_MAX_ROWS-1:0] ROW_ENABLE,
    // system outputs
    output logic EXT_IRQ,
    output logic POWERDOWN_SELECT
);

    // byte addresses of the registers
    localparam logic [KPSC_AW-1:0] ADDR_STATUS = {KPSC_IDX_PAD, KPSC_IDX_STATUS, KPSC_WORD_PAD};
    localparam logic [KPSC_AW-1:0] ADDR_SIZE = {KPSC_IDX_PAD, KPSC_IDX_SIZE, KPSC_WORD_PAD};
    localparam logic [KPSC_AW-1:0] ADDR_ORD_LO = {KPSC_IDX_PAD, KPSC_IDX_ORD_LO, KPSC_WORD_PAD};
    localparam logic [KPSC_AW-1:0] ADDR_ORD_HI = {KPSC_IDX_PAD, KPSC_IDX_ORD_HI, KPSC_WORD_PAD};
    localparam logic [KPSC_AW-1:0] ADDR_MANUAL = {KPSC_IDX_PAD, KPSC_IDX_MANUAL, KPSC_WORD_PAD};
    localparam logic [KPSC_AW-1:0] ADDR_IRQ = {KPSC_IDX_PAD, KPSC_IDX_IRQ, KPSC_WORD_PAD};

    // register storage
    logic [7:0] size_ff;
    logic [7:0] ord_lo_ff;
    logic [7:0] ord_hi_ff;
    logic [KPSC_MAX_COLS-1:0] manual_ff;
    logic auto_scan_enable_ff;
    logic key_detect_flag_ff;
    logic keypad_irq_flag_ff;
    logic keypad_irq_enable_ff;
    logic serial_bus_irq_flag_ff;
    logic serial_bus_irq_enable_ff;
    logic clock_alarm_irq_flag_ff;
    logic clock_alarm_irq_enable_ff;
    logic powerdown_select_ff;
    logic ext_irq_ff;
    logic [KPSC_MAX_ROWS-1:0] row_enable_ff;
    logic [7:0] prdata_ff;

    // next values
    logic [7:0] nxt_size;
    logic [7:0] nxt_ord_lo;
    logic [7:0] nxt_ord_hi;
    logic [KPSC_MAX_COLS-1:0] nxt_manual;
    logic nxt_auto;
    logic nxt_key_detect;
    logic nxt_kp_flag;
    logic nxt_sb_flag;
    logic nxt_ca_flag;
    logic [7:0] nxt_irq_ctl_w;
    logic nxt_ext_irq;
    logic [KPSC_MAX_ROWS-1:0] nxt_row_enable;

    // bus decode
    logic hit_status;
    logic hit_size;
    logic hit_ord_lo;
    logic hit_ord_hi;
    logic hit_manual;
    logic hit_irq;
    logic hit_any;
    logic access;
    logic wr_done;
    logic rd_setup;
    logic rd_done;
    logic lane0;
    logic [7:0] wbyte;

    // composed register views
    logic [7:0] status_view;
    logic [7:0] irq_view;
    logic [7:0] rd_mux;
    logic [KPSC_CNT_W-1:0] row_count;
    logic [KPSC_CNT_W-1:0] column_count;
    logic [KPSC_CNT_W-1:0] row_eff;
    logic [KPSC_ORDER_W-1:0] column_order;
    logic [KPSC_SLOT_W-1:0] first_scan_slot;
    logic [KPSC_SLOT_W-1:0] second_scan_slot;
    logic [KPSC_SLOT_W-1:0] third_scan_slot;
    logic [KPSC_SLOT_W-1:0] fourth_scan_slot;
    logic [KPSC_SLOT_W-1:0] fifth_scan_slot;
    kpsc_scan_cfg_t scan_cfg;
    logic [KPSC_SLOT_W-1:0] scan_slot;
    logic [KPSC_MAX_COLS-1:0] col_drive;

    // clear-on-read strobes
    logic clr_key_detect;
    logic clr_kp_flag;
    logic clr_sb_flag;
    logic clr_ca_flag;

    // address decode; misaligned or foreign addresses hit nothing
    assign hit_status = (PADDR == ADDR_STATUS);
    assign hit_size = (PADDR == ADDR_SIZE);
    assign hit_ord_lo = (PADDR == ADDR_ORD_LO);
    assign hit_ord_hi = (PADDR == ADDR_ORD_HI);
    assign hit_manual = (PADDR == ADDR_MANUAL);
    assign hit_irq = (PADDR == ADDR_IRQ);
    assign hit_any = hit_status | hit_size | hit_ord_lo | hit_ord_hi | hit_manual | hit_irq;

    // apb phases; the slave never inserts wait states
    assign access = PSEL & PENABLE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign rd_done = access & ~PWRITE & hit_any;
    assign lane0 = PSTRB[0];
    assign wr_done = access & PWRITE & hit_any & lane0;
    assign wbyte = PWDATA[7:0];

    // apb answer
    assign PREADY = access;
    assign PSLVERR = access & ~hit_any;
    assign PRDATA = {24'h000000, prdata_ff};

    // row and column counts and the order bytes
    assign row_count = size_ff[KPSC_ROW_LSB +: KPSC_CNT_W];
    assign column_count = size_ff[KPSC_COL_LSB +: KPSC_CNT_W];
    assign column_order = {fifth_scan_slot, fourth_scan_slot, third_scan_slot,
                           second_scan_slot, first_scan_slot};

    // slot views; slot three straddles the two bytes
    assign first_scan_slot = ord_lo_ff[2:0];
    assign second_scan_slot = ord_lo_ff[5:3];
    assign third_scan_slot = {ord_hi_ff[0], ord_lo_ff[7:6]};
    assign fourth_scan_slot = ord_hi_ff[3:1];
    assign fifth_scan_slot = ord_hi_ff[6:4];

    // row mask: clamp to the six row pins, idle when not auto scanning
    assign row_eff = (row_count > KPSC_MAX_ROWS_C) ? KPSC_MAX_ROWS_C : row_count;

    // row enables in bypass stay zero so firmware owns the matrix
    always_comb begin
        nxt_row_enable = '0;
        for (int r = 0; r < KPSC_MAX_ROWS; r++) begin
            if (auto_scan_enable_ff && (KPSC_CNT_W'(r) < row_eff)) begin
                nxt_row_enable[r] = 1'b1;
            end
        end
    end

    // configuration handed to the sequencer
    assign scan_cfg.auto_scan_enable = auto_scan_enable_ff;
    assign scan_cfg.column_count = column_count;
    assign scan_cfg.column_order = column_order;
    assign scan_cfg.manual_columns = manual_ff;

    // register read views; unused bits read zero
    assign status_view = {5'h00, auto_scan_enable_ff, key_detect_flag_ff, 1'b0};
    assign irq_view = {powerdown_select_ff, 1'b0, clock_alarm_irq_enable_ff,
                       clock_alarm_irq_flag_ff, serial_bus_irq_enable_ff,
                       serial_bus_irq_flag_ff, keypad_irq_enable_ff,
                       keypad_irq_flag_ff};

    // read multiplexer
    assign rd_mux = hit_status ? status_view :
                    hit_size ? size_ff :
                    hit_ord_lo ? ord_lo_ff :
                    hit_ord_hi ? ord_hi_ff :
                    hit_manual ? {3'h0, manual_ff} :
                    hit_irq ? irq_view : KPSC_RST_BYTE;

    // only flags that were captured as one are cleared, so an event
    // landing between setup and access survives the read
    assign clr_key_detect = rd_done & hit_status & prdata_ff[KPSC_ST_KEY_DETECT_FLAG];
    assign clr_kp_flag = rd_done & hit_irq & prdata_ff[KPSC_IRQ_KP_FLAG];
    assign clr_sb_flag = rd_done & hit_irq & prdata_ff[KPSC_IRQ_SB_FLAG];
    assign clr_ca_flag = rd_done & hit_irq & prdata_ff[KPSC_IRQ_CA_FLAG];

    // sticky flags; the set always wins over a clear in the same cycle
    assign nxt_key_detect = KEY_FOUND | (key_detect_flag_ff & ~clr_key_detect);
    assign nxt_kp_flag = KEY_FOUND | (keypad_irq_flag_ff & ~clr_kp_flag);
    assign nxt_sb_flag = USB_EVENT | (serial_bus_irq_flag_ff & ~clr_sb_flag);
    assign nxt_ca_flag = RTC_EVENT | (clock_alarm_irq_flag_ff & ~clr_ca_flag);

    // writable control fields
    assign nxt_size = (wr_done & hit_size) ? (wbyte & KPSC_SIZE_WMASK) : size_ff;
    assign nxt_ord_lo = (wr_done & hit_ord_lo) ? wbyte : ord_lo_ff;
    assign nxt_ord_hi = (wr_done & hit_ord_hi) ? (wbyte & KPSC_ORD_HI_WMASK) : ord_hi_ff;
    assign nxt_manual = (wr_done & hit_manual) ? (wbyte[4:0] & KPSC_MANUAL_WMASK) : manual_ff;
    assign nxt_auto = (wr_done & hit_status) ? wbyte[KPSC_ST_AUTO] : auto_scan_enable_ff;

    // enables and powerdown select; flag bits and bit 6 ignore writes
    assign nxt_irq_ctl_w = (wr_done & hit_irq) ? (wbyte & KPSC_IRQ_WMASK) : irq_view;

    // shared request: any flag with its enable
    assign nxt_ext_irq = (nxt_kp_flag & nxt_irq_ctl_w[KPSC_IRQ_KP_EN]) |
                         (nxt_sb_flag & nxt_irq_ctl_w[KPSC_IRQ_SB_EN]) |
                         (nxt_ca_flag & nxt_irq_ctl_w[KPSC_IRQ_CA_EN]);

    // keypad configuration registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            size_ff <= KPSC_RST_BYTE;
            ord_lo_ff <= KPSC_RST_BYTE;
            ord_hi_ff <= KPSC_RST_BYTE;
            manual_ff <= '0;
            auto_scan_enable_ff <= 1'b0;
        end else begin
            size_ff <= nxt_size;
            ord_lo_ff <= nxt_ord_lo;
            ord_hi_ff <= nxt_ord_hi;
            manual_ff <= nxt_manual;
            auto_scan_enable_ff <= nxt_auto;
        end
    end

    // interrupt control register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            keypad_irq_enable_ff <= 1'b0;
            serial_bus_irq_enable_ff <= 1'b0;
            clock_alarm_irq_enable_ff <= 1'b0;
            powerdown_select_ff <= 1'b0;
        end else begin
            keypad_irq_enable_ff <= nxt_irq_ctl_w[KPSC_IRQ_KP_EN];
            serial_bus_irq_enable_ff <= nxt_irq_ctl_w[KPSC_IRQ_SB_EN];
            clock_alarm_irq_enable_ff <= nxt_irq_ctl_w[KPSC_IRQ_CA_EN];
            powerdown_select_ff <= nxt_irq_ctl_w[KPSC_IRQ_PD_SEL];
        end
    end

    // event flags
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            key_detect_flag_ff <= 1'b0;
            keypad_irq_flag_ff <= 1'b0;
            serial_bus_irq_flag_ff <= 1'b0;
            clock_alarm_irq_flag_ff <= 1'b0;
        end else begin
            key_detect_flag_ff <= nxt_key_detect;
            keypad_irq_flag_ff <= nxt_kp_flag;
            serial_bus_irq_flag_ff <= nxt_sb_flag;
            clock_alarm_irq_flag_ff <= nxt_ca_flag;
        end
    end

    // registered outputs and read capture in the setup cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_irq_ff <= 1'b0;
            row_enable_ff <= '0;
            prdata_ff <= KPSC_RST_BYTE;
        end else begin
            ext_irq_ff <= nxt_ext_irq;
            row_enable_ff <= nxt_row_enable;
            prdata_ff <= rd_setup ? rd_mux : prdata_ff;
        end
    end

    // column sequencer
    kpsc_scan u_scan (
        .clk(CLK),
        .rst_n(RST_N),
        .cfg(scan_cfg),
        .tick(SCAN_TICK),
        .slot_ff(scan_slot),
        .col_drive_ff(col_drive)
    );

    // pins
    assign COL_DRIVE = col_drive;
    assign SCAN_SLOT = scan_slot;
    assign ROW_ENABLE = row_enable_ff;
    assign EXT_IRQ = ext_irq_ff;
    assign POWERDOWN_SELECT = powerdown_select_ff;

endmodule : kpsc_top

`default_nettype wire

// >>> testbench/kpsc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module kpsc_monitor
    import kpsc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // apb requests and read data
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [KPSC_AW-1:0] PADDR,
    input wire logic [KPSC_DW-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [KPSC_DW-1:0] PRDATA,
    // events
    input wire logic SCAN_TICK,
    input wire logic KEY_FOUND,
    input wire logic RTC_EVENT,
    input wire logic USB_EVENT,
    // watched outputs
    input wire logic [KPSC_MAX_COLS-1:0] COL_DRIVE,
    input wire logic [KPSC_SLOT_W-1:0] SCAN_SLOT,
    input wire logic [KPSC_MAX_ROWS-1:0] ROW_ENABLE,
    input wire logic EXT_IRQ,
    input wire logic POWERDOWN_SELECT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    function automatic logic [KPSC_AW-1:0] ba(input logic [15:0] idx);
        return KPSC_AW'({idx, KPSC_IDX_PAD});
    endfunction : ba

    // shadows follow accepted writes only; flags are hardware owned and not shadowed
    logic [7:0] st_ff, sz_ff, lo_ff, hi_ff, man_ff, irq_ff;
    logic [2:0] quiet_ff;
    wire logic wr = PSEL && PENABLE && PWRITE && PSTRB[0];
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            {st_ff, sz_ff, lo_ff, hi_ff, man_ff, irq_ff} <= '0;
            quiet_ff <= 3'h0;
        end else begin
            quiet_ff <= wr ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
            if (wr && PADDR == ba(KPSC_IDX_STATUS)) st_ff <= PWDATA[7:0];
            if (wr && PADDR == ba(KPSC_IDX_SIZE)) sz_ff <= PWDATA[7:0];
            if (wr && PADDR == ba(KPSC_IDX_ORD_LO)) lo_ff <= PWDATA[7:0];
            if (wr && PADDR == ba(KPSC_IDX_ORD_HI)) hi_ff <= PWDATA[7:0];
            if (wr && PADDR == ba(KPSC_IDX_MANUAL)) man_ff <= PWDATA[7:0];
            if (wr && PADDR == ba(KPSC_IDX_IRQ)) irq_ff <= PWDATA[7:0];
        end
    end

    // expected scan view; checks wait a few quiet cycles so config writes can land
    wire logic auto_on = st_ff[KPSC_ST_AUTO];
    wire logic settled = quiet_ff >= 3'h3;
    wire logic [2:0] cnt = (sz_ff[2:0] > KPSC_MAX_COLS_C) ? KPSC_MAX_COLS_C : sz_ff[2:0];
    wire logic [2:0] rows = sz_ff[5:3];
    wire logic [5:0] rmask = (rows >= KPSC_MAX_ROWS_C) ? 6'h3F : 6'((7'h01 << rows) - 7'h01);
    wire logic [14:0] order = {hi_ff[6:0], lo_ff};
    wire logic [2:0] sel = 3'(order >> (SCAN_SLOT * 3));
    wire logic [4:0] col_exp = (sel <= 3'h4) ? 5'(5'h01 << sel) : 5'h00;
    wire logic [2:0] slot_nxt = (SCAN_SLOT >= cnt - 3'h1) ? 3'h0 : SCAN_SLOT + 3'h1;
    wire logic pair_on = (PRDATA[0] & PRDATA[1]) | (PRDATA[2] & PRDATA[3]) |
                         (PRDATA[4] & PRDATA[5]);

    sequence s_irq_acc;
        PSEL && PENABLE && !PWRITE && PADDR == ba(KPSC_IDX_IRQ);
    endsequence
    sequence s_irq_setup;
        PSEL && !PENABLE && !PWRITE && PADDR == ba(KPSC_IDX_IRQ);
    endsequence
    property p_clr(int b, logic evt);
        s_irq_acc ##0 (PRDATA[b] && !evt) ##1 s_irq_setup |=> !PRDATA[b];
    endproperty
    property p_set(logic evt, logic en);
        evt && en |-> ##1 EXT_IRQ;
    endproperty

    kp_clear_a: assert property (p_clr(0, KEY_FOUND)) else $error("keypad flag kept");
    ca_clear_a: assert property (p_clr(4, RTC_EVENT)) else $error("alarm flag kept");
    sb_clear_a: assert property (p_clr(2, USB_EVENT)) else $error("bus flag kept");
    kp_raise_a: assert property (p_set(KEY_FOUND, irq_ff[1])) else $error("no key irq");
    ca_raise_a: assert property (p_set(RTC_EVENT, irq_ff[5])) else $error("no alarm irq");
    sb_raise_a: assert property (p_set(USB_EVENT, irq_ff[3])) else $error("no bus irq");
    irq_pair_a: assert property (s_irq_acc ##0 pair_on |-> EXT_IRQ)
        else $error("irq low");
    pd_follow_a: assert property (quiet_ff >= 3'h2 |-> POWERDOWN_SELECT == irq_ff[7])
        else $error("powerdown select wrong");
    slot_step_a: assert property (auto_on && settled && cnt >= 3'h2 && SCAN_TICK
        |=> SCAN_SLOT == $past(slot_nxt)) else $error("slot step wrong");
    col_sel_a: assert property (auto_on && settled && cnt != 3'h0 && $stable(SCAN_SLOT)
        |-> COL_DRIVE == col_exp) else $error("column drive wrong");
    bypass_drive_a: assert property (!auto_on && settled
        |-> COL_DRIVE == man_ff[4:0] && SCAN_SLOT == 3'h0 && ROW_ENABLE == 6'h00)
        else $error("bypass drive wrong");
    row_mask_a: assert property (auto_on && settled |-> ROW_ENABLE == rmask)
        else $error("row enable wrong");
endmodule : kpsc_monitor

bind kpsc_top kpsc_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .SCAN_TICK(SCAN_TICK), .KEY_FOUND(KEY_FOUND), .RTC_EVENT(RTC_EVENT),
    .USB_EVENT(USB_EVENT), .COL_DRIVE(COL_DRIVE), .SCAN_SLOT(SCAN_SLOT),
    .ROW_ENABLE(ROW_ENABLE), .EXT_IRQ(EXT_IRQ), .POWERDOWN_SELECT(POWERDOWN_SELECT));
`default_nettype wire

// >>> testbench/kpsc_keypad_model.sv
`timescale 1ns/10ps
`default_nettype none
module kpsc_keypad_model
    import kpsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // scan lines from the block
    input wire logic [KPSC_MAX_COLS-1:0] col_drive,
    input wire logic [KPSC_MAX_ROWS-1:0] row_enable,
    // key held by the bench
    input wire logic pressed,
    input wire logic [2:0] key_row,
    input wire logic [2:0] key_col,
    // detector output
    output logic key_found
);
    logic hit_ff;
    // a switch closes a path only while its column is driven and its row is scanned
    wire logic hit = pressed && col_drive[key_col] && row_enable[key_row];
    // one pulse per closure; a held key does not repeat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_ff <= 1'b0;
            key_found <= 1'b0;
        end else begin
            hit_ff <= hit;
            key_found <= hit && !hit_ff;
        end
    end
endmodule : kpsc_keypad_model
`default_nettype wire

// >>> testbench/kpsc_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module kpsc_tb_top
    import kpsc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [KPSC_AW-1:0] paddr = '0;
    logic [KPSC_DW-1:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, ext_irq, pd_sel, key_model;
    logic tick = 1'b0, kf = 1'b0, rtc = 1'b0, usb = 1'b0, pressed = 1'b0;
    logic [4:0] col_drive;
    logic [2:0] scan_slot;
    logic [5:0] row_en;
    int miscompares = 0, compares = 0;
    // 200 MHz system clock
    always #2.5 clk = ~clk;

    kpsc_top dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .SCAN_TICK(tick), .KEY_FOUND(kf | key_model), .RTC_EVENT(rtc),
        .USB_EVENT(usb), .COL_DRIVE(col_drive), .SCAN_SLOT(scan_slot), .ROW_ENABLE(row_en),
        .EXT_IRQ(ext_irq), .POWERDOWN_SELECT(pd_sel));
    kpsc_keypad_model pad (.clk(clk), .rst_n(rst_n), .col_drive(col_drive),
        .row_enable(row_en), .pressed(pressed), .key_row(3'h1), .key_col(3'h2),
        .key_found(key_model));

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; hold leaves the bus up so a setup can follow at once
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
        input bit hold);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= KPSC_AW'({idx, KPSC_IDX_PAD});
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        if (!hold) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb

    task automatic rdchk(input string what, input logic [15:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00, 1'b0);
        chk(what, rd, {24'h0, exp});
    endtask : rdchk

    // one-cycle pulses on {tick, rtc, usb, kf}
    task automatic ev(input logic [3:0] m);
        {tick, rtc, usb, kf} <= m;
        @(posedge clk);
        {tick, rtc, usb, kf} <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : ev

    task automatic t_fields();
        rdchk("size", KPSC_IDX_SIZE, 8'h00);
        rdchk("ord_lo", KPSC_IDX_ORD_LO, 8'h00);
        rdchk("ord_hi", KPSC_IDX_ORD_HI, 8'h00);
        apb(KPSC_IDX_SIZE, 1'b1, 8'hFF, 1'b0);
        rdchk("size", KPSC_IDX_SIZE, 8'h3F);
        apb(KPSC_IDX_ORD_HI, 1'b1, 8'hFF, 1'b0);
        rdchk("ord_hi", KPSC_IDX_ORD_HI, 8'h7F);
        apb(KPSC_IDX_IRQ, 1'b1, 8'hFF, 1'b0);
        rdchk("irq", KPSC_IDX_IRQ, 8'hAA);
        chk("pd", pd_sel, 1);
        chk("bypass_rows", row_en, 0);
        apb(16'h00E0, 1'b0, 8'h00, 1'b0);
        chk("slverr", err, 1);
        $display("test fields done");
    endtask : t_fields

    task automatic t_flags();
        for (int i = 0; i < 3; i++) begin
            apb(KPSC_IDX_IRQ, 1'b1, 8'h00, 1'b0);
            ev(4'(1 << i));
            chk("masked", ext_irq, 0);
            apb(KPSC_IDX_IRQ, 1'b1, 8'(2 << (2 * i)), 1'b0);
            @(posedge clk);
            chk("irq_on", ext_irq, 1);
            apb(KPSC_IDX_IRQ, 1'b0, 8'h00, 1'b1);
            chk("flag", rd, 3 << (2 * i));
            rdchk("cleared", KPSC_IDX_IRQ, 8'(2 << (2 * i)));
            @(posedge clk);
            chk("irq_off", ext_irq, 0);
        end
        apb(KPSC_IDX_IRQ, 1'b1, 8'h2A, 1'b0);
        ev(4'h7);
        chk("irq_all", ext_irq, 1);
        rdchk("all", KPSC_IDX_IRQ, 8'h3F);
        rdchk("detect", KPSC_IDX_STATUS, 8'h02);
        rdchk("detect_clr", KPSC_IDX_STATUS, 8'h00);
        $display("test flags done");
    endtask : t_flags

    // order lo/hi, size, then count check over n+2 ticks of expected column list
    task automatic t_scan(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] sz,
        input int n, input logic [5:0] rows, input bit rev);
        apb(KPSC_IDX_STATUS, 1'b1, 8'h00, 1'b0);
        apb(KPSC_IDX_ORD_LO, 1'b1, lo, 1'b0);
        apb(KPSC_IDX_ORD_HI, 1'b1, hi, 1'b0);
        apb(KPSC_IDX_SIZE, 1'b1, sz, 1'b0);
        apb(KPSC_IDX_STATUS, 1'b1, 8'h04, 1'b0);
        repeat (2) @(posedge clk);
        for (int k = 0; k < n + 2; k++) begin
            chk("col", col_drive, 1 << (rev ? 4 - (k % n) : k % n));
            chk("rows", row_en, rows);
            ev(4'h8);
        end
        $display("test scan done");
    endtask : t_scan

    task automatic t_bypass();
        pressed <= 1'b0;
        rdchk("key", KPSC_IDX_STATUS, 8'h06);
        rdchk("kp_flag", KPSC_IDX_IRQ, 8'h2B);
        apb(KPSC_IDX_STATUS, 1'b1, 8'h00, 1'b0);
        apb(KPSC_IDX_MANUAL, 1'b1, 8'h15, 1'b0);
        repeat (2) @(posedge clk);
        chk("manual", col_drive, 5'h15);
        chk("slot", scan_slot, 0);
        chk("rows_off", row_en, 0);
        $display("test bypass done");
    endtask : t_bypass

    // main sequence: reset for ten cycles, then each scenario in turn
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_fields();
        t_flags();
        t_scan(8'h88, 8'h46, 8'h3D, 5, 6'h3F, 1'b0);
        pressed <= 1'b1;
        t_scan(8'h9C, 8'h02, 8'h13, 3, 6'h03, 1'b1);
        t_bypass();
        stop_test();
    end
endmodule : kpsc_tb_top
`default_nettype wire
